/* logic/fcu_cmd_table.sv */
// Translation of a requested operation into its one or two bus write cycles.
module fcu_cmd_table (
    input wire logic [3:0] op,
    input wire logic [7:0] user_data,
    output logic [1:0] cycles,
    output logic [7:0] first_code,
    output logic [7:0] second_code,
    output logic legal
);
    always_comb begin
        cycles = 2'h1;
        first_code = fcu_pkg::CMD_READ_ARRAY;
        second_code = fcu_pkg::CMD_CONFIRM;
        legal = 1'b1;
        unique case (op)
            fcu_pkg::OP_READ_ARRAY: first_code = fcu_pkg::CMD_READ_ARRAY;
            fcu_pkg::OP_READ_ID: first_code = fcu_pkg::CMD_READ_ID;
            fcu_pkg::OP_READ_STATUS: first_code = fcu_pkg::CMD_READ_STATUS;
            fcu_pkg::OP_CLEAR_STATUS: first_code = fcu_pkg::CMD_CLEAR_STATUS;
            fcu_pkg::OP_SUSPEND: first_code = fcu_pkg::CMD_SUSPEND;
            fcu_pkg::OP_RESUME: first_code = fcu_pkg::CMD_CONFIRM;
            fcu_pkg::OP_ERASE: begin
                cycles = 2'h2;
                first_code = fcu_pkg::CMD_ERASE_SETUP;
            end
            fcu_pkg::OP_PROGRAM: begin
                cycles = 2'h2;
                first_code = fcu_pkg::CMD_PROGRAM_SETUP;
                second_code = user_data;
            end
            fcu_pkg::OP_LOCK_BLOCK: begin
                cycles = 2'h2;
                first_code = fcu_pkg::CMD_LOCK_SETUP;
                second_code = fcu_pkg::CMD_LOCK_BLOCK;
            end
            fcu_pkg::OP_LOCK_MASTER: begin
                cycles = 2'h2;
                first_code = fcu_pkg::CMD_LOCK_SETUP;
                second_code = fcu_pkg::CMD_LOCK_MASTER;
            end
            fcu_pkg::OP_CLEAR_LOCKS: begin
                cycles = 2'h2;
                first_code = fcu_pkg::CMD_LOCK_SETUP;
            end
            default: legal = 1'b0;
        endcase
    end
endmodule

/* logic/fcu_host.sv */
// Host controller that drives the flash command interface through its pins.
module fcu_host #(
    parameter int ADDR_W = 20,
    parameter int STROBE_CYCLES = fcu_pkg::STROBE_CYCLES,
    parameter int POWERDOWN_CYCLES = fcu_pkg::POWERDOWN_CYCLES
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic [3:0] REQ_OP,
    input wire logic [ADDR_W-1:0] REQ_ADDR,
    input wire logic [7:0] REQ_DATA,
    input wire logic REQ_OVERRIDE,
    output logic RSP_VALID,
    output logic [7:0] RSP_DATA,
    output logic RSP_REFUSED,
    output logic [ADDR_W-1:0] FLASH_ADDR,
    output logic [7:0] DATA_BUS_OUT,
    output logic DATA_BUS_OE,
    input wire logic [7:0] DATA_BUS_IN,
    output logic CHIP_SELECT_N,
    output logic OUTPUT_ENABLE_N,
    output logic WRITE_STROBE_N,
    output logic POWERDOWN_RESET_N,
    output logic OVERRIDE_HIGH_LEVEL,
    output logic PROGRAM_SUPPLY_HIGH,
    input wire logic READY_BUSY_N,
    output logic BUSY
);
    localparam int CW = $clog2(STROBE_CYCLES + POWERDOWN_CYCLES + 2);
    fcu_pkg::fcu_state_t state_q;
    logic [CW-1:0] count_q;
    logic second_q;
    logic [3:0] op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [7:0] wdata_q;
    logic override_q;
    logic [1:0] cycles;
    logic [7:0] first_code;
    logic [7:0] second_code;
    logic legal;
    logic alters;
    logic strobe_done;
    logic pd_done;

    fcu_cmd_table u_table (
        .op(op_q),
        .user_data(wdata_q),
        .cycles(cycles),
        .first_code(first_code),
        .second_code(second_code),
        .legal(legal)
    );

    assign strobe_done = count_q == CW'(STROBE_CYCLES - 1);
    assign pd_done = count_q == CW'(POWERDOWN_CYCLES - 1);
    assign alters = op_q inside {fcu_pkg::OP_ERASE, fcu_pkg::OP_PROGRAM, fcu_pkg::OP_LOCK_BLOCK,
        fcu_pkg::OP_LOCK_MASTER, fcu_pkg::OP_CLEAR_LOCKS};
    // Handshake is combinational; a new order waits for the pin sequence to end.
    assign REQ_READY = state_q == fcu_pkg::ST_IDLE;
    // The supply is raised only for altering orders, so a stray write cannot change contents.
    assign PROGRAM_SUPPLY_HIGH = alters && state_q != fcu_pkg::ST_IDLE;
    assign BUSY = !READY_BUSY_N;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_q <= fcu_pkg::ST_IDLE;
            count_q <= '0;
            second_q <= 1'b0;
        end else begin
            unique case (state_q)
                fcu_pkg::ST_IDLE: begin
                    count_q <= '0;
                    second_q <= 1'b0;
                    if (REQ_VALID) begin
                        if (REQ_OP == fcu_pkg::OP_POWERDOWN) begin
                            state_q <= fcu_pkg::ST_PD;
                        end else if (REQ_OP == fcu_pkg::OP_READ) begin
                            state_q <= fcu_pkg::ST_READ;
                        end else begin
                            state_q <= fcu_pkg::ST_SETUP;
                        end
                    end
                end
                fcu_pkg::ST_SETUP: begin
                    // Unknown orders never reach the pins, so no reserved code is written.
                    state_q <= legal ? fcu_pkg::ST_STROBE : fcu_pkg::ST_IDLE;
                end
                fcu_pkg::ST_STROBE: begin
                    count_q <= count_q + 1'b1;
                    if (strobe_done) begin
                        count_q <= '0;
                        state_q <= fcu_pkg::ST_GAP;
                    end
                end
                fcu_pkg::ST_GAP: begin
                    if (cycles == 2'h2 && !second_q) begin
                        second_q <= 1'b1;
                        state_q <= fcu_pkg::ST_STROBE;
                    end else begin
                        state_q <= fcu_pkg::ST_IDLE;
                    end
                end
                fcu_pkg::ST_READ: begin
                    count_q <= count_q + 1'b1;
                    if (strobe_done) begin
                        count_q <= '0;
                        state_q <= fcu_pkg::ST_IDLE;
                    end
                end
                fcu_pkg::ST_PD: begin
                    count_q <= count_q + 1'b1;
                    if (pd_done) begin
                        count_q <= '0;
                        state_q <= fcu_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            op_q <= fcu_pkg::OP_READ_ARRAY;
            addr_q <= '0;
            wdata_q <= 8'h00;
            override_q <= 1'b0;
        end else if (REQ_VALID && REQ_READY) begin
            op_q <= REQ_OP;
            addr_q <= REQ_ADDR;
            wdata_q <= REQ_DATA;
            // Override level for locked blocks and master lock work.
            override_q <= REQ_OVERRIDE;
        end
    end

    // Pin drive: select and strobe fall together and rise together, so latching is well defined.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            CHIP_SELECT_N <= 1'b1;
            WRITE_STROBE_N <= 1'b1;
            OUTPUT_ENABLE_N <= 1'b1;
            DATA_BUS_OE <= 1'b0;
            DATA_BUS_OUT <= 8'h00;
            FLASH_ADDR <= '0;
            POWERDOWN_RESET_N <= 1'b1;
            OVERRIDE_HIGH_LEVEL <= 1'b0;
        end else begin
            POWERDOWN_RESET_N <= state_q != fcu_pkg::ST_PD;
            OVERRIDE_HIGH_LEVEL <= state_q != fcu_pkg::ST_IDLE && override_q;
            FLASH_ADDR <= addr_q;
            if (state_q == fcu_pkg::ST_STROBE && !strobe_done) begin
                CHIP_SELECT_N <= 1'b0;
                WRITE_STROBE_N <= 1'b0;
                OUTPUT_ENABLE_N <= 1'b1;
                DATA_BUS_OE <= 1'b1;
                DATA_BUS_OUT <= second_q ? second_code : first_code;
            end else if (state_q == fcu_pkg::ST_READ && !strobe_done) begin
                // The host releases the bus before output enable falls to avoid contention.
                CHIP_SELECT_N <= 1'b0;
                WRITE_STROBE_N <= 1'b1;
                OUTPUT_ENABLE_N <= 1'b0;
                DATA_BUS_OE <= 1'b0;
            end else begin
                // Deselecting is safe while busy; the device completes its operation.
                CHIP_SELECT_N <= 1'b1;
                WRITE_STROBE_N <= 1'b1;
                OUTPUT_ENABLE_N <= 1'b1;
                // The byte stays driven one cycle past the strobe rise, so the device latch has hold time.
                DATA_BUS_OE <= state_q == fcu_pkg::ST_STROBE;
            end
        end
    end

    // Read data is sampled in the last read cycle, whatever mode the device stands in.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RSP_VALID <= 1'b0;
            RSP_DATA <= 8'h00;
            RSP_REFUSED <= 1'b0;
        end else begin
            RSP_VALID <= (state_q == fcu_pkg::ST_READ && strobe_done) || (state_q == fcu_pkg::ST_SETUP && !legal)
                || (state_q == fcu_pkg::ST_GAP && !(cycles == 2'h2 && !second_q));
            RSP_REFUSED <= state_q == fcu_pkg::ST_SETUP && !legal;
            if (state_q == fcu_pkg::ST_READ && strobe_done) begin
                RSP_DATA <= DATA_BUS_IN;
            end
        end
    end
endmodule

/* logic/fcu_pkg.sv */
// Package with command codes, pin timing counts and operation kinds for the flash command controller.
package fcu_pkg;
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_ID = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
    localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_SETUP_ALT = 8'h10;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_BLOCK = 8'h01;
    localparam logic [7:0] CMD_LOCK_MASTER = 8'hF1;
    localparam logic [19:0] ID_ADDR_MAKER = 20'h00000;
    localparam logic [19:0] ID_ADDR_DEVICE = 20'h00001;
    localparam logic [15:0] ID_ADDR_BLOCK_LOCK = 16'h0002;
    localparam logic [19:0] ID_ADDR_MASTER_LOCK = 20'h00003;
    localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;
    localparam int STROBE_NS = 64;
    localparam int CLK_NS = 8;
    localparam int STROBE_CYCLES = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int POWERDOWN_NS = 100;
    localparam int POWERDOWN_CYCLES = (POWERDOWN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] OP_READ_ARRAY = 4'h0;
    localparam logic [3:0] OP_READ_ID = 4'h1;
    localparam logic [3:0] OP_READ_STATUS = 4'h2;
    localparam logic [3:0] OP_CLEAR_STATUS = 4'h3;
    localparam logic [3:0] OP_ERASE = 4'h4;
    localparam logic [3:0] OP_PROGRAM = 4'h5;
    localparam logic [3:0] OP_SUSPEND = 4'h6;
    localparam logic [3:0] OP_RESUME = 4'h7;
    localparam logic [3:0] OP_LOCK_BLOCK = 4'h8;
    localparam logic [3:0] OP_LOCK_MASTER = 4'h9;
    localparam logic [3:0] OP_CLEAR_LOCKS = 4'hA;
    localparam logic [3:0] OP_READ = 4'hB;
    localparam logic [3:0] OP_POWERDOWN = 4'hC;
    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_GAP, ST_READ, ST_PD} fcu_state_t;
endpackage

/* verification/fcu_flash_model.sv */
// Behavioural flash device answering the host controller at its pins.
module fcu_flash_model #(
    parameter logic [7:0] MAKER = 8'h3C, // Arbitrary identification value.
    parameter logic [7:0] DEVICE = 8'h5E, // Arbitrary identification value.
    parameter int BUSY_NS = 300
) (
    input wire logic [19:0] addr,
    input wire logic [7:0] dq_in,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic pwr_n,
    input wire logic ovr,
    input wire logic vpp,
    output logic rb_n,
    output logic [7:0] dq,
    output logic dq_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [logic [19:0]];
    logic [15:0] lock_q = 16'h0000;
    logic master_q = 1'b0;
    logic err_q = 1'b0;
    logic [1:0] mode_q = 2'h0;
    logic [7:0] setup_q = 8'h00;
    logic deny;
    logic bad;
    logic [7:0] last_q = 8'h00;
    logic wr;
    logic [3:0] blk;
    initial rb_n = 1'b1;
    assign blk = addr[19:16];
    assign wr = !ce_n && !we_n;
    assign dq_en = !ce_n && !oe_n && pwr_n;
    always #2 begin
        if (mode_q == 2'h2) dq = {rb_n, 6'h00, err_q};
        else if (mode_q == 2'h0) dq = mem.exists(addr) ? mem[addr] : 8'hFF;
        else if (addr[1:0] == 2'h0) dq = MAKER;
        else if (addr[1:0] == 2'h1) dq = DEVICE;
        else dq = {7'h00, addr[0] ? master_q : lock_q[blk]};
    end
    always @(negedge pwr_n) begin
        mode_q = 2'h0;
        err_q = 1'b0;
        setup_q = 8'h00;
        rb_n = 1'b1;
    end
    // The first rising strobe ends the write, so latching on the fall of wr covers both orders.
    always @(negedge wr) begin
        if (pwr_n === 1'b1) last_q = dq_in;
        if (pwr_n === 1'b1 && setup_q != 8'h00) begin
            deny = !vpp;
            if (setup_q == 8'h60) deny = deny || (!ovr && (master_q || dq_in == 8'hF1));
            else deny = deny || (lock_q[blk] && !ovr);
            bad = setup_q == 8'h20 && dq_in != 8'hD0;
            bad = bad || (setup_q == 8'h60 && !(dq_in inside {8'h01, 8'hF1, 8'hD0}));
            if (bad || deny) begin
                err_q = 1'b1;
            end else begin
                if (setup_q == 8'h20) for (int i = 0; i < 65536; i++) mem.delete({blk, i[15:0]});
                else if (setup_q != 8'h60) mem[addr] = dq_in;
                else if (dq_in == 8'h01) lock_q[blk] = 1'b1;
                else if (dq_in == 8'hF1) master_q = 1'b1;
                else lock_q = 16'h0000;
                fork begin
                    rb_n = 1'b0;
                    #(BUSY_NS) rb_n = 1'b1;
                end join_none
            end
            setup_q = 8'h00;
            mode_q = 2'h2;
        end else if (pwr_n === 1'b1) begin
            // Suspend and resume fall to default: operations here end too soon to need them.
            case (dq_in)
                8'hFF: mode_q = 2'h0;
                8'h90: mode_q = 2'h1;
                8'h70: mode_q = 2'h2;
                8'h50: err_q = 1'b0;
                8'h20, 8'h40, 8'h10, 8'h60: setup_q = dq_in;
                default: ;
            endcase
        end
    end
endmodule

/* verification/fcu_host_asserts.sv */
// Pin-level checker for the flash host controller.
module fcu_host_checker #(
    parameter int POWERDOWN_CYCLES = 13
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic RSP_VALID,
    input wire logic RSP_REFUSED,
    input wire logic [19:0] FLASH_ADDR,
    input wire logic [7:0] DATA_BUS_OUT,
    input wire logic DATA_BUS_OE,
    input wire logic CHIP_SELECT_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic WRITE_STROBE_N,
    input wire logic POWERDOWN_RESET_N,
    input wire logic PROGRAM_SUPPLY_HIGH,
    input wire logic READY_BUSY_N,
    input wire logic BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    logic [7:0] pd_cnt_q;
    always_ff @(posedge CLOCK) begin
        if (RST || POWERDOWN_RESET_N) pd_cnt_q <= 8'h00;
        else pd_cnt_q <= pd_cnt_q + 8'h01;
    end
    oe_we_excl_a: assert property (!(!OUTPUT_ENABLE_N && !WRITE_STROBE_N))
        else $error("Read and write strobes low together.");
    select_write_a: assert property ($fell(WRITE_STROBE_N) |-> !CHIP_SELECT_N && DATA_BUS_OE)
        else $error("Write strobe without select or driven data.");
    latch_hold_a: assert property (!WRITE_STROBE_N && !$past(WRITE_STROBE_N) |->
        $stable(DATA_BUS_OUT) && $stable(FLASH_ADDR)) else $error("Address or data moved during a write.");
    data_hold_a: assert property ($rose(WRITE_STROBE_N) |->
        DATA_BUS_OE && $stable(DATA_BUS_OUT) && $stable(FLASH_ADDR)) else $error("Data released with the strobe.");
    busy_mirror_a: assert property (BUSY == !READY_BUSY_N)
        else $error("Busy flag does not follow the device.");
    supply_alter_a: assert property (!WRITE_STROBE_N && DATA_BUS_OUT inside {8'h20, 8'h40, 8'h10, 8'h60} |->
        PROGRAM_SUPPLY_HIGH) else $error("Setup code written with a low supply.");
    codes_legal_a: assert property (!WRITE_STROBE_N && !PROGRAM_SUPPLY_HIGH |->
        DATA_BUS_OUT inside {8'hFF, 8'h90, 8'h70, 8'h50, 8'hB0, 8'hD0}) else $error("Undefined command code written.");
    bus_turn_a: assert property (DATA_BUS_OE |-> OUTPUT_ENABLE_N)
        else $error("Host drives data while reading.");
    refuse_quiet_a: assert property (RSP_REFUSED |-> RSP_VALID && CHIP_SELECT_N && $past(CHIP_SELECT_N))
        else $error("Refused order touched the pins.");
    pd_width_a: assert property ($rose(POWERDOWN_RESET_N) |-> pd_cnt_q >= 8'(POWERDOWN_CYCLES))
        else $error("Power-down pulse too short.");
endmodule
bind fcu_host fcu_host_checker #(.POWERDOWN_CYCLES(POWERDOWN_CYCLES)) u_chk (.*);

/* verification/testbench.sv */
// Self-checking bench for the flash host controller against a device model.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] MAKER = 8'h3C; // Arbitrary identification value.
    logic CLOCK = 1'b0, RST = 1'b1, REQ_VALID = 1'b0, REQ_OVERRIDE = 1'b0, refused;
    logic [3:0] REQ_OP = 4'h0;
    logic [19:0] REQ_ADDR = 20'h00000, FLASH_ADDR;
    logic [7:0] REQ_DATA = 8'h00, flt_q = 8'h5A, got, RSP_DATA, DATA_BUS_OUT, DATA_BUS_IN, dev_dq;
    logic REQ_READY, RSP_VALID, RSP_REFUSED, DATA_BUS_OE, CHIP_SELECT_N, OUTPUT_ENABLE_N, WRITE_STROBE_N;
    logic POWERDOWN_RESET_N, OVERRIDE_HIGH_LEVEL, PROGRAM_SUPPLY_HIGH, READY_BUSY_N, BUSY, dev_en, bsy;
    int n_mismatch = 0, checks_done = 0;
    always #4 CLOCK = ~CLOCK;
    // A floating bus must not look like stale data, so it shows a moving pattern.
    always @(posedge CLOCK) flt_q <= ~flt_q;
    assign DATA_BUS_IN = DATA_BUS_OE ? DATA_BUS_OUT : dev_en ? dev_dq : flt_q;
    fcu_host u_dut (.*);
    fcu_flash_model #(.MAKER(MAKER)) u_dev (.addr(FLASH_ADDR), .dq_in(DATA_BUS_IN), .ce_n(CHIP_SELECT_N),
        .oe_n(OUTPUT_ENABLE_N), .we_n(WRITE_STROBE_N), .pwr_n(POWERDOWN_RESET_N), .ovr(OVERRIDE_HIGH_LEVEL),
        .vpp(PROGRAM_SUPPLY_HIGH), .rb_n(READY_BUSY_N), .dq(dev_dq), .dq_en(dev_en));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic order(input logic [3:0] op, input logic [19:0] a, input logic [7:0] d, input logic ov = 1'b0);
        @(posedge CLOCK);
        REQ_VALID <= 1'b1;
        REQ_OP <= op;
        REQ_ADDR <= a;
        REQ_DATA <= d;
        REQ_OVERRIDE <= ov;
        do @(posedge CLOCK); while (REQ_READY !== 1'b1);
        REQ_VALID <= 1'b0;
        @(posedge CLOCK);
        while (op == 4'hC ? REQ_READY !== 1'b1 : RSP_VALID !== 1'b1) @(posedge CLOCK);
        got = RSP_DATA;
        refused = RSP_REFUSED;
        bsy = BUSY;
        repeat (2) @(posedge CLOCK);
        while (BUSY !== 1'b0) @(posedge CLOCK);
    endtask
    task automatic rd(input logic [19:0] a);
        order(4'hB, a, 8'h00);
    endtask
    task automatic t_program;
        order(4'h1, 20'h00000, 8'h00);
        rd(20'h00000);
        chk(got, MAKER);
        order(4'h5, 20'h12345, 8'h5A);
        chk({7'h00, bsy}, 8'h01);
        rd(20'h12345);
        chk(got, 8'h80);
        chk({7'h00, bsy}, 8'h00);
        order(4'h0, 20'h00000, 8'h00);
        rd(20'h12345);
        chk(got, 8'h5A);
        order(4'h4, 20'h12000, 8'h00);
        order(4'h0, 20'h00000, 8'h00);
        rd(20'h12345);
        chk(got, 8'hFF);
        order(4'h6, 20'h00000, 8'h00);
        chk(u_dev.last_q, 8'hB0);
        order(4'h7, 20'h00000, 8'h00);
        chk(u_dev.last_q, 8'hD0);
        order(4'hD, 20'h00000, 8'h00);
        chk({7'h00, refused}, 8'h01);
    endtask
    task automatic t_locks;
        order(4'h8, 20'h30000, 8'h00);
        order(4'h5, 20'h30010, 8'h11);
        rd(20'h30010);
        chk(got, 8'h81);
        order(4'h3, 20'h00000, 8'h00);
        rd(20'h30010);
        chk(got, 8'h80);
        order(4'h5, 20'h30010, 8'h22, 1'b1);
        order(4'h9, 20'h00000, 8'h00);
        order(4'h9, 20'h00000, 8'h00, 1'b1);
        order(4'hA, 20'h00000, 8'h00);
        order(4'h1, 20'h00000, 8'h00);
        rd(20'h00003);
        chk(got, 8'h01);
        rd(20'h30002);
        chk(got, 8'h01);
        order(4'hA, 20'h00000, 8'h00, 1'b1);
        order(4'h1, 20'h00000, 8'h00);
        rd(20'h30002);
        chk(got, 8'h00);
        order(4'hC, 20'h00000, 8'h00);
        rd(20'h30010);
        chk(got, 8'h22);
        order(4'h2, 20'h00000, 8'h00);
        rd(20'h00000);
        chk(got, 8'h80);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #300000;
        n_mismatch++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge CLOCK);
        RST <= 1'b0;
        t_program();
        t_locks();
        final_report();
    end
endmodule
